// ==== rtl/drive_io_defs.svh ====
`ifndef DRIVE_IO_DEFS_SVH
`define DRIVE_IO_DEFS_SVH

// timing
`define CLK_PERIOD_NS 10
`define MS_IN_NS 1000000
`define SCAN_PERIOD_MS 2
`define DOUT_PERIOD_MS 1
`define ADC_PERIOD_MS 4

// command source value that hands control to the terminal inputs
`define CMD_SRC_TERMINAL 2'h2

// input function codes
`define FC_DISABLED 7'h00
`define FC_RUN 7'h01
`define FC_RUN_REV 7'h02
`define FC_COAST 7'h03
`define FC_QUICK 7'h04
`define FC_FAULT_ACK 7'h09
`define FC_JOG_RIGHT 7'h0a
`define FC_JOG_LEFT 7'h0b
`define FC_REVERSE 7'h0c
`define FC_SP_UP 7'h0d
`define FC_SP_DOWN 7'h0e
`define FC_FSP_DIRECT 7'h0f
`define FC_FSP_DIRECT_RUN 7'h10
`define FC_FSP_BINARY_RUN 7'h11
`define FC_DC_BRAKE 7'h19
`define FC_EXT_TRIP 7'h1d
`define FC_ADDL_SP_OFF 7'h21
`define FC_FREE_ROUTE 7'h63

// routing selector: 0 = no source, 1..4 = monitor bit of input 1..4
`define ROUTE_NONE 3'h0
`define NUM_CMDS 14

// debounce lengths in scans per setting
`define DEB_LEN_0 4'h1
`define DEB_LEN_1 4'h3
`define DEB_LEN_2 4'h6
`define DEB_LEN_3 4'hc

// analog input configuration codes
`define AIN_CFG_VOLT 3'h0
`define AIN_CFG_VOLT_BRK 3'h1
`define AIN_CFG_CURR 3'h2
`define AIN_CFG_CURR_BRK 3'h3
`define AIN_CFG_BIPOLAR 3'h4

// analog-as-digital threshold (half scale) and sample fraction bits
`define AIN_DIG_THRESHOLD 10'h200
`define FILT_FRAC_BITS 6

`endif

// ==== rtl/drive_io_pkg.sv ====
package drive_io_pkg;

	typedef logic [6:0] func_code_t;

	typedef struct packed {
		logic run;
		logic run_rev;
		logic coast_stop;
		logic quick_stop;
		logic fault_ack;
		logic jog_right;
		logic jog_left;
		logic reverse;
		logic setpoint_up;
		logic setpoint_down;
		logic fixed_sp_run;
		logic dc_brake;
		logic ext_trip;
		logic addl_sp_disable;
	} drive_cmd_t;

	typedef struct packed {
		logic [3:0] select;
		logic binary;
	} fixed_sp_t;

	typedef struct packed {
		logic word_two;
		logic [3:0] bit_pos;
	} out_sel_t;

	typedef struct packed {
		logic [3:0] cnt;
		logic state;
	} deb_state_t;

	typedef struct packed {
		logic [16:0] ms_cnt;
		logic [1:0] ms_sub;
		logic [3:0] monitor;
		drive_cmd_t cmds;
		fixed_sp_t fixed_sp;
		logic dout;
		logic [15:0] filt;
		logic [11:0] setpoint;
		logic [15:0] brk_cnt;
		logic brk_status;
		logic brk_fault;
	} io_state_t;

endpackage

// ==== rtl/drive_io_processing.sv ====
// Functional notes
// - three digital inputs plus a fourth taken from the analog input
// - polarity selects whether 0 V or 24 V reads as logic one
// - inputs are debounced and exposed as routable monitor bits
// - codes 0..4: disabled, run, run reversed, coast stop, quick stop
// - codes 9..14: fault ack, jog right/left, reverse, setpoint up/down
// - codes 15..17: fixed setpoint direct, direct plus run, binary plus run
// - codes 25, 29, 33: dc braking, external trip, extra setpoint off
// - code 99 frees the input; any command may take a monitor bit
// - digital output follows one status bit picked by word and position
// - status word one bits 0..7 carry readiness, fault and stop states
// - status word one bits 8..15 carry deviation, limits and overloads
// - status word two carries brake, frequency and current flags
// - analog input is voltage by default; config selects other modes
// - analog path: low-pass filter, then scaling, then dead zone
// - first-order filter with programmable time constant
// - at or below half dead zone for break delay raises fault and status
// - break detection needs enable and nonzero dead zone width
// - break monitoring only for unipolar inputs
`include "drive_io_defs.svh"

module drive_io_processing #(
	parameter int MS_CYCLES = `MS_IN_NS / `CLK_PERIOD_NS
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [2:0] digital_input_raw,
	input wire logic input_polarity_select,
	input wire logic [1:0] input_debounce_setting,
	input wire drive_io_pkg::func_code_t [3:0] input_function_code,
	input wire logic [1:0] command_source_select,
	input wire logic [`NUM_CMDS-1:0][2:0] run_stop_source,
	input wire drive_io_pkg::out_sel_t output_bit_select,
	input wire logic [15:0] status_word_one,
	input wire logic [15:0] status_word_two,
	input wire logic [9:0] analog_sample,
	input wire logic [2:0] analog_input_config,
	input wire logic [3:0] analog_filter_constant,
	input wire logic [9:0] analog_scale_gain,
	input wire logic [11:0] dead_zone_width,
	input wire logic [15:0] break_delay_time,
	output logic [3:0] input_state_monitor,
	output drive_io_pkg::drive_cmd_t drive_commands,
	output drive_io_pkg::fixed_sp_t fixed_setpoint,
	output logic digital_output,
	output logic [11:0] analog_setpoint,
	output logic [1:0] analog_status_bits,
	output logic analog_break_fault
);
	logic rst_meta_q, rst_sync_q;
	drive_io_pkg::io_state_t q, d;
	logic [3:0] raw_in;
	logic [3:0] deb;
	logic tick_ms;
	logic scan_tick;
	logic adc_tick;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// one millisecond prescaler feeds all three periodic ticks
	assign tick_ms = (q.ms_cnt == 17'(MS_CYCLES - 1));
	assign scan_tick = tick_ms && q.ms_sub[0];
	assign adc_tick = tick_ms && (q.ms_sub == 2'h3);

	// input level is high when 24 V is present; polarity flips it for 0 V wiring
	assign raw_in[2:0] = digital_input_raw ^ {3{input_polarity_select}};
	assign raw_in[3] = (analog_sample >= `AIN_DIG_THRESHOLD);

	for (genvar i = 0; i < 4; i++) begin : g_deb
		input_debounce u_deb (
			.clock(clock),
			.rst_n(rst_sync_q),
			.scan_tick(scan_tick),
			.raw(raw_in[i]),
			.setting(input_debounce_setting),
			.state(deb[i])
		);
	end

	always_comb begin
		drive_io_pkg::drive_cmd_t cmd;
		logic [`NUM_CMDS-1:0] cmd_vec;
		drive_io_pkg::fixed_sp_t fsp;
		logic [16:0] x_ext;
		logic signed [17:0] diff;
		logic signed [17:0] step;
		logic [19:0] prod;
		logic [11:0] scaled;
		logic [9:0] ain;
		logic brk_en;
		logic brk_cond;
		cmd = '0;
		cmd_vec = '0;
		fsp = '0;
		x_ext = '0;
		diff = '0;
		step = '0;
		prod = '0;
		scaled = '0;
		ain = '0;
		brk_en = 1'b0;
		brk_cond = 1'b0;
		d = q;

		d.ms_cnt = tick_ms ? 17'h0 : q.ms_cnt + 17'h1;
		if (tick_ms) begin
			d.ms_sub = q.ms_sub + 2'h1;
		end
		d.monitor = deb;

		// fixed decoding; each input ORs its state into the coded command
		for (int i = 0; i < 4; i++) begin
			case (input_function_code[i])
				`FC_DISABLED: ;
				`FC_RUN: cmd.run = cmd.run | q.monitor[i];
				`FC_RUN_REV: cmd.run_rev = cmd.run_rev | q.monitor[i];
				`FC_COAST: cmd.coast_stop = cmd.coast_stop | q.monitor[i];
				`FC_QUICK: cmd.quick_stop = cmd.quick_stop | q.monitor[i];
				`FC_FAULT_ACK: cmd.fault_ack = cmd.fault_ack | q.monitor[i];
				`FC_JOG_RIGHT: cmd.jog_right = cmd.jog_right | q.monitor[i];
				`FC_JOG_LEFT: cmd.jog_left = cmd.jog_left | q.monitor[i];
				`FC_REVERSE: cmd.reverse = cmd.reverse | q.monitor[i];
				`FC_SP_UP: cmd.setpoint_up = cmd.setpoint_up | q.monitor[i];
				`FC_SP_DOWN: cmd.setpoint_down = cmd.setpoint_down | q.monitor[i];
				`FC_FSP_DIRECT: fsp.select[i] = q.monitor[i];
				`FC_FSP_DIRECT_RUN: begin
					fsp.select[i] = q.monitor[i];
					cmd.fixed_sp_run = cmd.fixed_sp_run | q.monitor[i];
				end
				`FC_FSP_BINARY_RUN: begin
					fsp.select[i] = q.monitor[i];
					fsp.binary = 1'b1;
					cmd.fixed_sp_run = cmd.fixed_sp_run | q.monitor[i];
				end
				`FC_DC_BRAKE: cmd.dc_brake = cmd.dc_brake | q.monitor[i];
				`FC_EXT_TRIP: cmd.ext_trip = cmd.ext_trip | q.monitor[i];
				`FC_ADDL_SP_OFF: cmd.addl_sp_disable = cmd.addl_sp_disable | q.monitor[i];
				default: ; // free routing and unknown codes decode nothing
			endcase
		end

		// free routing: every command may pick any input flagged as free
		cmd_vec = cmd;
		for (int c = 0; c < `NUM_CMDS; c++) begin
			for (int i = 0; i < 4; i++) begin
				if (run_stop_source[c] == 3'(i + 1) &&
						input_function_code[i] == `FC_FREE_ROUTE) begin
					cmd_vec[c] = cmd_vec[c] | q.monitor[i];
				end
			end
		end
		cmd = cmd_vec;

		// terminal commands count only while the terminal strip owns control
		if (command_source_select == `CMD_SRC_TERMINAL) begin
			d.cmds = cmd;
			d.fixed_sp = fsp;
		end else begin
			d.cmds = '0;
			d.fixed_sp = '0;
		end

		// status words are inputs; bit meanings belong to the drive core
		if (tick_ms) begin
			d.dout = output_bit_select.word_two ?
				status_word_two[output_bit_select.bit_pos] :
				status_word_one[output_bit_select.bit_pos];
		end

		// analog channel: a large constant smooths more but slows loops
		if (adc_tick) begin
			x_ext = {1'b0, analog_sample, 6'h0};
			diff = $signed({1'b0, x_ext}) - $signed({2'b00, q.filt});
			step = diff >>> analog_filter_constant;
			d.filt = 16'($signed({2'b00, q.filt}) + step);
		end
		ain = q.filt[15:`FILT_FRAC_BITS];
		prod = {10'h000, ain} * {10'h000, analog_scale_gain};
		scaled = prod[19:8];
		d.setpoint = (scaled <= dead_zone_width) ? 12'h0 : scaled - dead_zone_width;

		// monitoring only on unipolar modes that request it
		brk_en = (analog_input_config == `AIN_CFG_VOLT_BRK) ||
			(analog_input_config == `AIN_CFG_CURR_BRK);
		brk_cond = brk_en && (dead_zone_width != 12'h0) &&
			({2'b00, ain} <= (dead_zone_width >> 1));
		if (!brk_cond) begin
			d.brk_cnt = 16'h0;
			d.brk_status = 1'b0;
		end else if (tick_ms) begin
			if (q.brk_cnt >= break_delay_time) begin
				d.brk_status = 1'b1;
			end else begin
				d.brk_cnt = q.brk_cnt + 16'h1;
			end
		end
		// acknowledge clears the fault only once the wire is back; set wins
		if (d.brk_status) begin
			d.brk_fault = 1'b1;
		end else if (d.cmds.fault_ack) begin // ack only counts under terminal control
			d.brk_fault = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign input_state_monitor = q.monitor;
	assign drive_commands = q.cmds;
	assign fixed_setpoint = q.fixed_sp;
	assign digital_output = q.dout;
	assign analog_setpoint = q.setpoint;
	assign analog_status_bits = {q.brk_fault, q.brk_status};
	assign analog_break_fault = q.brk_fault;
endmodule // drive_io_processing

// ==== rtl/input_debounce.sv ====
`include "drive_io_defs.svh"

module input_debounce (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic scan_tick,
	input wire logic raw,
	input wire logic [1:0] setting,
	output logic state
);
	drive_io_pkg::deb_state_t q, d;
	logic [3:0] len;

	always_comb begin
		case (setting)
			2'h0: len = `DEB_LEN_0;
			2'h1: len = `DEB_LEN_1;
			2'h2: len = `DEB_LEN_2;
			default: len = `DEB_LEN_3;
		endcase
		d = q;
		// a new level must hold for len consecutive scans before it is taken
		if (scan_tick) begin
			if (raw == q.state) begin
				d.cnt = 4'h0;
			end else if (q.cnt + 4'h1 >= len) begin
				d.cnt = 4'h0;
				d.state = raw;
			end else begin
				d.cnt = q.cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign state = q.state;
endmodule // input_debounce

// ==== test/drive_io_partner.sv ====
module drive_io_partner (
	input wire logic [2:0] closed,
	input wire logic to_zero,
	input wire logic wire_ok,
	input wire logic [9:0] level,
	output logic [2:0] raw,
	output logic [9:0] sample
);
	timeunit 1ns;
	timeprecision 1ns;
	// a switch wired to 0 v pulls its terminal low when closed
	assign raw = to_zero ? ~closed : closed;
	// a broken wire reads zero; a live sensor stays clear of the break band
	assign sample = wire_ok ? level : 10'h000;
endmodule // drive_io_partner

// ==== test/drive_io_processing_asserts.sv ====
`include "drive_io_defs.svh"

module drive_io_processing_asserts #(
	parameter int MS_CYCLES = 20
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [1:0] command_source_select,
	input wire drive_io_pkg::func_code_t [3:0] input_function_code,
	input wire drive_io_pkg::out_sel_t output_bit_select,
	input wire logic [15:0] status_word_one,
	input wire logic [15:0] status_word_two,
	input wire logic [2:0] analog_input_config,
	input wire logic [11:0] dead_zone_width,
	input wire logic [3:0] input_state_monitor,
	input wire drive_io_pkg::drive_cmd_t drive_commands,
	input wire logic digital_output,
	input wire logic [1:0] analog_status_bits,
	input wire logic analog_break_fault
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic sel_bit;
	logic brk_ok;
	assign sel_bit = output_bit_select.word_two ? status_word_two[output_bit_select.bit_pos]
		: status_word_one[output_bit_select.bit_pos];
	// bipolar mode is left out on purpose: break monitoring is unipolar only
	assign brk_ok = (analog_input_config == 3'h1 || analog_input_config == 3'h3)
		&& dead_zone_width != 12'h000;
	sequence s_status_rise;
		$rose(analog_status_bits[0]);
	endsequence
	sequence s_fault_rise;
		$rose(analog_break_fault);
	endsequence
	chk_cmd_gate: assert property ((command_source_select != 2'h2) |=> drive_commands == '0)
		else $error("commands pass while source is not terminal");
	chk_fault_lag: assert property (s_status_rise |=> analog_break_fault)
		else $error("fault did not follow break status");
	chk_fault_cause: assert property (s_fault_rise |-> analog_status_bits[0])
		else $error("fault rose without break status");
	chk_brk_enable: assert property (s_status_rise |-> $past(brk_ok))
		else $error("break status with monitoring off");
	chk_fault_hold: assert property ($fell(analog_break_fault) |-> !$past(analog_status_bits[0]))
		else $error("fault cleared while break persists");
	chk_fault_mirror: assert property (analog_status_bits[1] == analog_break_fault)
		else $error("status fault bit differs from fault");
	chk_status_cond: assert property (analog_status_bits[0] |-> $past(brk_ok))
		else $error("break status held with monitoring off");
	chk_dout_follow: assert property ($changed(digital_output) |-> digital_output == $past(sel_bit))
		else $error("output took a wrong status bit");
	chk_monitor_hold: assert property ($changed(input_state_monitor[0])
		|=> $stable(input_state_monitor[0])[*8])
		else $error("monitor bit changed faster than scan");
	chk_run_follow: assert property ($rose(input_state_monitor[0]) && input_function_code[0] == 7'h01
		&& command_source_select == 2'h2 |=> drive_commands.run)
		else $error("run did not follow input one");
endmodule // drive_io_processing_asserts

bind drive_io_processing drive_io_processing_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (.*);

// ==== test/test_drive_io_processing.sv ====
module test_drive_io_processing;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {bit [1:0] k; logic [18:0] m; logic [18:0] v;} note_t;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] digital_input_raw;
	logic input_polarity_select = 1'b0;
	logic [1:0] input_debounce_setting = 2'h0;
	drive_io_pkg::func_code_t [3:0] input_function_code = '0;
	logic [1:0] command_source_select = 2'h2;
	logic [13:0][2:0] run_stop_source = '0;
	drive_io_pkg::out_sel_t output_bit_select = '0;
	logic [15:0] status_word_one = 16'h0000;
	logic [15:0] status_word_two = 16'h0000;
	logic [9:0] analog_sample;
	logic [2:0] analog_input_config = 3'h0;
	logic [3:0] analog_filter_constant = 4'h0;
	logic [9:0] analog_scale_gain = 10'h100;
	logic [11:0] dead_zone_width = 12'h100;
	logic [15:0] break_delay_time = 16'h0005;
	logic [3:0] input_state_monitor;
	drive_io_pkg::drive_cmd_t drive_commands;
	drive_io_pkg::fixed_sp_t fixed_setpoint;
	logic digital_output;
	logic [11:0] analog_setpoint;
	logic [1:0] analog_status_bits;
	logic analog_break_fault;
	logic [2:0] closed = 3'h0;
	logic wire_ok = 1'b1;
	int fails = 0;
	int compares = 0;
	int seed = 83972;
	int cyc = 0;
	note_t q[$];
	event chk_ev;
	// index 14 means the code raises no command
	localparam int codes[18] = '{0, 1, 2, 3, 4, 9, 10, 11, 12, 13, 14, 15, 16, 17, 25, 29, 33, 99};
	localparam int idx[18] = '{14, 13, 12, 11, 10, 9, 8, 7, 6, 5, 4, 14, 3, 3, 2, 1, 0, 14};

	drive_io_processing #(.MS_CYCLES(20)) u_dut (.*);
	drive_io_partner u_far (.closed(closed), .to_zero(input_polarity_select), .wire_ok(wire_ok),
		.level(10'h3ff), .raw(digital_input_raw), .sample(analog_sample));

	always #5 clock = ~clock;

	task automatic summarize();
		if (fails == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic step(int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic note(bit [1:0] k, logic [18:0] m, logic [18:0] v);
		q.push_back('{k, m, v});
		-> chk_ev;
	endtask

	task automatic cmp_cmd(logic [18:0] v);
		compares++;
		if ({drive_commands, fixed_setpoint} !== v) begin
			fails++;
			$display("MISMATCH %0t commands %h want %h", $time, {drive_commands, fixed_setpoint}, v);
		end
	endtask

	task automatic cmp_sp(logic [11:0] v);
		compares++;
		if (analog_setpoint !== v) begin
			fails++;
			$display("MISMATCH %0t setpoint %h want %h", $time, analog_setpoint, v);
		end
	endtask

	task automatic cmp_stat(logic [7:0] m, logic [7:0] v);
		logic [7:0] o;
		o = {input_state_monitor, digital_output, analog_status_bits, analog_break_fault};
		compares++;
		if ((o & m) !== v) begin
			fails++;
			$display("MISMATCH %0t status %h want %h", $time, o & m, v);
		end
	endtask

	always begin
		@(chk_ev);
		// look after the edge's register updates, not in a race with them
		#1;
		while (q.size() > 0) begin
			if (q[0].k == 2'h1) cmp_stat(q[0].m[7:0], q[0].v[7:0]);
			else if (q[0].k == 2'h2) cmp_sp(q[0].v[11:0]);
			else cmp_cmd(q[0].v);
			void'(q.pop_front());
		end
	end

	// the whole run needs about 6250 cycles
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			$display("MISMATCH %0t timeout", $time);
			summarize();
		end
	end

	initial begin
		step(6);
		rst_n <= 1'b1;
		step(10);
		for (int i = 0; i < 18; i++) begin
			logic [18:0] v;
			input_polarity_select <= 1'($random(seed));
			closed <= 3'h0;
			command_source_select <= 2'h2;
			step(100);
			input_function_code[0] <= 7'(codes[i]);
			closed <= 3'h1;
			step(100);
			v = '0;
			if (idx[i] < 14) v[idx[i] + 5] = 1'b1;
			if (codes[i] inside {15, 16, 17}) v[1] = 1'b1;
			if (codes[i] == 17) v[0] = 1'b1;
			note(0, '1, v);
			command_source_select <= 2'h1;
			step(10);
			note(0, '1, 19'h0);
		end
		input_function_code <= {7'h00, 7'h00, 7'h63, 7'h63};
		command_source_select <= 2'h2;
		run_stop_source[13] <= 3'h2;
		closed <= 3'h2;
		step(100);
		note(0, '1, 19'h40000);
		note(1, 8'hf0, 8'ha0);
		input_debounce_setting <= 2'h3;
		closed <= 3'h0;
		step(200);
		note(1, 8'h20, 8'h20);
		step(400);
		note(1, 8'h20, 8'h00);
		input_debounce_setting <= 2'h0;
		input_function_code <= '0;
		run_stop_source <= '0;
		for (int i = 0; i < 8; i++) begin
			logic b;
			status_word_one <= 16'($random(seed));
			status_word_two <= 16'($random(seed));
			output_bit_select <= 5'($random(seed));
			step(30);
			b = output_bit_select.word_two ? status_word_two[output_bit_select.bit_pos]
				: status_word_one[output_bit_select.bit_pos];
			note(1, 8'h08, {b, 3'h0});
		end
		note(2, '1, 19'h002ff);
		wire_ok <= 1'b0;
		step(400);
		note(1, 8'h07, 8'h00);
		note(2, '1, 19'h00000);
		analog_input_config <= 3'h1;
		step(400);
		note(1, 8'h07, 8'h07);
		wire_ok <= 1'b1;
		step(200);
		note(1, 8'h07, 8'h05);
		input_function_code[2] <= 7'h09;
		closed <= 3'h4;
		step(100);
		note(1, 8'h07, 8'h00);
		closed <= 3'h0;
		analog_input_config <= 3'h4;
		wire_ok <= 1'b0;
		step(400);
		note(1, 8'h07, 8'h00);
		step(10);
		summarize();
	end
endmodule // test_drive_io_processing
